// File: rtl/csr_clock_regs.sv
// Clock select, receiver option and interrupt mask registers with parallel address/data strobe register access
`timescale 1ns/1ps
`default_nettype none
module csr_clock_regs #(
   parameter logic [1:0] RX_POST_SCALE = 2'b10
) (
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   input  wire logic [csr_pkg::ADDR_W-1:0]  addr,
   input  wire logic [csr_pkg::DATA_W-1:0]  wr_data,
   input  wire logic                        rx_mode,
   input  wire logic                        pll_clock_a,
   input  wire logic                        pll_clock_b,
   input  wire logic                        oscillator_clock,
   input  wire logic                        lock_loss_toggle,
   input  wire logic                        invalid_event,
   input  wire logic                        channel_status_update_event,
   input  wire logic                        transmission_error_event,
   input  wire logic                        non_audio_toggle,
   input  wire logic                        copy_permission_toggle,
   input  wire logic                        deemphasis_toggle,
   input  wire logic                        received_rate_toggle,
   input  wire logic                        rx_data_invalid,
   input  wire logic [23:0]                 rx_sample_in,
   output logic      [csr_pkg::DATA_W-1:0]  rd_data,
   output logic      [1:0]                  post_scale_select,
   output logic                             fractional_enable,
   output logic                             master_clock_sel,
   output logic                             master_clock_divider,
   output logic      [1:0]                  clock_pin_divider,
   output logic                             clock_pin_sel,
   output logic                             clock_output_pin_o,
   output logic                             clock_output_pin_oe,
   output logic                             receiver_input_type,
   output logic      [23:0]                 rx_sample_out,
   output logic                             irq_n,
   output logic                             device_reset
);
   import csr_pkg::*;

   csr_evt_if evt ();

   logic [7:0]  post_div_q, post_div_d;
   logic [7:0]  clk_src_q, clk_src_d;
   logic [7:0]  rx_in_q, rx_in_d;
   logic [7:0]  mask_q, mask_d;
   logic [7:0]  rd_data_q, rd_data_d;
   logic [1:0]  post_q, post_d;
   logic        frac_q, frac_d;
   logic        mdiv_q, mdiv_d;
   logic [1:0]  pdiv_q, pdiv_d;
   logic        psel_q, psel_d;
   logic        msel_q, msel_d;
   logic        pin_q, pin_d;
   logic        pin_oe_q, pin_oe_d;
   logic        rxt_q, rxt_d;
   logic [23:0] samp_q, samp_d;
   logic        irq_n_q;
   logic        dev_rst_q;
   csr_state_t  state_q, state_d;
   logic        bank_rst;
   logic        bank_rst_q;

   assign bank_rst = sys_rst || (state_q == CSR_RESET);

   // Reset echo keeps checks quiet on the edge after a bank reset
   always_ff @(posedge ref_clk) begin
      bank_rst_q <= bank_rst;
   end

   // Register access sequencing: a write to the reset address resets the bank
   always_comb begin
      state_d = CSR_IDLE;
      case (state_q)
         CSR_IDLE: begin
            if (wr_en) begin
               state_d = (addr == ADDR_DEV_RESET) ? CSR_RESET : CSR_WRITE;
            end
         end
         CSR_WRITE: begin
            if (wr_en) begin
               state_d = (addr == ADDR_DEV_RESET) ? CSR_RESET : CSR_WRITE;
            end
         end
         CSR_RESET: state_d = CSR_IDLE;
         default:   state_d = CSR_IDLE;
      endcase
   end

   always_comb begin
      post_div_d = post_div_q;
      clk_src_d  = clk_src_q;
      rx_in_d    = rx_in_q;
      mask_d     = mask_q;
      if (wr_en) begin
         case (addr)
            ADDR_POST_DIV: post_div_d = wr_data & MASK_POST_DIV;
            ADDR_CLK_SRC:  clk_src_d  = wr_data & MASK_CLK_SRC;
            ADDR_RX_INPUT: rx_in_d    = wr_data & MASK_RX_INPUT;
            ADDR_INT_MASK: mask_d     = wr_data & MASK_INT_MASK;
            default: begin
            end
         endcase
      end
      case (addr)
         ADDR_POST_DIV:   rd_data_d = post_div_q;
         ADDR_CLK_SRC:    rd_data_d = clk_src_q;
         ADDR_RX_INPUT:   rd_data_d = rx_in_q;
         ADDR_INT_MASK:   rd_data_d = mask_q;
         ADDR_INT_STATUS: rd_data_d = evt.status;
         default:         rd_data_d = 8'h00;
      endcase
      if (!rd_en) begin
         rd_data_d = rd_data_q;
      end
   end

   always_comb begin
      post_d = rx_mode ? RX_POST_SCALE : post_div_q[POST_SCALE_LO +: 2];
      frac_d = post_div_q[FRAC_EN_BIT];
      mdiv_d = post_div_q[MCLK_DIV_BIT] & ~clk_src_q[MCLK_SRC_BIT];
      pdiv_d = clk_src_q[PIN_SRC_BIT] ? 2'b00 : post_div_q[PIN_DIV_LO +: 2];
      msel_d = clk_src_q[MCLK_SRC_BIT];
      psel_d = clk_src_q[PIN_SRC_BIT];
      pin_d  = clk_src_q[PIN_SRC_BIT] ? oscillator_clock : pll_clock_a;
      pin_oe_d = clk_src_q[PIN_EN_BIT];
      rxt_d = rx_in_q[RX_TYPE_BIT];
      samp_d = rx_sample_in;
      if (rx_data_invalid && !clk_src_q[IGN_INV_BIT]) begin
         samp_d = clk_src_q[FILL_BIT] ? 24'h000000 : samp_q;
      end
   end

   assign evt.raw_event = {received_rate_toggle, deemphasis_toggle, copy_permission_toggle,
                           non_audio_toggle, transmission_error_event,
                           channel_status_update_event,
                           invalid_event & ~clk_src_q[IGN_INV_BIT], lock_loss_toggle};
   assign evt.int_mask    = mask_q;
   assign evt.status_read = rd_en && (addr == ADDR_INT_STATUS);

   csr_int_status u_status (
      .ref_clk (ref_clk),
      .rst     (bank_rst),
      .evt     (evt)
   );

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_q <= CSR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (bank_rst) begin
         post_div_q <= RST_POST_DIV;
         clk_src_q  <= RST_CLK_SRC;
         rx_in_q    <= RST_RX_INPUT;
         mask_q     <= RST_INT_MASK;
         rd_data_q  <= 8'h00;
         post_q     <= RST_POST_DIV[POST_SCALE_LO +: 2];
         frac_q     <= RST_POST_DIV[FRAC_EN_BIT];
         mdiv_q     <= 1'b0;
         pdiv_q     <= 2'b00;
         psel_q     <= RST_CLK_SRC[PIN_SRC_BIT];
         msel_q     <= RST_CLK_SRC[MCLK_SRC_BIT];
         pin_q      <= 1'b0;
         pin_oe_q   <= RST_CLK_SRC[PIN_EN_BIT];
         rxt_q      <= RST_RX_INPUT[RX_TYPE_BIT];
         samp_q     <= 24'h000000;
         irq_n_q    <= 1'b1;
         dev_rst_q  <= 1'b0;
      end else begin
         post_div_q <= post_div_d;
         clk_src_q  <= clk_src_d;
         rx_in_q    <= rx_in_d;
         mask_q     <= mask_d;
         rd_data_q  <= rd_data_d;
         post_q     <= post_d;
         frac_q     <= frac_d;
         mdiv_q     <= mdiv_d;
         pdiv_q     <= pdiv_d;
         psel_q     <= psel_d;
         msel_q     <= msel_d;
         pin_q      <= pin_d;
         pin_oe_q   <= pin_oe_d;
         rxt_q      <= rxt_d;
         samp_q     <= samp_d;
         irq_n_q    <= ~evt.irq;
         dev_rst_q  <= state_d == CSR_RESET;
      end
   end

   assign rd_data              = rd_data_q;
   assign post_scale_select    = post_q;
   assign fractional_enable    = frac_q;
   assign master_clock_divider = mdiv_q;
   assign master_clock_sel     = msel_q;
   assign clock_pin_divider    = pdiv_q;
   assign clock_pin_sel        = psel_q;
   assign clock_output_pin_o   = pin_q;
   assign clock_output_pin_oe  = pin_oe_q;
   assign receiver_input_type  = rxt_q;
   assign rx_sample_out        = samp_q;
   assign irq_n                = irq_n_q;
   assign device_reset         = dev_rst_q;

   a_post_rx_force: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      rx_mode |=> post_scale_select == RX_POST_SCALE)
      else $error("Post-scale not forced in receive mode");
   a_post_user: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      !rx_mode |=> post_scale_select == $past(post_div_q[POST_SCALE_LO +: 2]))
      else $error("Post-scale does not follow field");
   a_frac_follow: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      ##1 fractional_enable == $past(post_div_q[FRAC_EN_BIT]))
      else $error("Fractional enable mismatch");
   a_mdiv_gate: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      clk_src_q[MCLK_SRC_BIT] |=> !master_clock_divider)
      else $error("Master divider active with oscillator source");
   a_pdiv_gate: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      clk_src_q[PIN_SRC_BIT] |=> clock_pin_divider == 2'b00)
      else $error("Pin divider active with oscillator source");
   a_pin_src_osc: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      clk_src_q[PIN_SRC_BIT] |=> clock_output_pin_o == $past(oscillator_clock))
      else $error("Clock pin not from oscillator");
   a_pin_enable: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      !clk_src_q[PIN_EN_BIT] |=> !clock_output_pin_oe)
      else $error("Clock pin driven while disabled");
   a_zero_fill: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      (rx_data_invalid && clk_src_q[FILL_BIT] && !clk_src_q[IGN_INV_BIT])
      |=> rx_sample_out == 24'h000000)
      else $error("Zero fill not applied");
   a_ignore_inv: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      clk_src_q[IGN_INV_BIT] |=> rx_sample_out == $past(rx_sample_in))
      else $error("Invalid flag not ignored");
   a_master_src: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      ##1 master_clock_sel == $past(clk_src_q[MCLK_SRC_BIT]))
      else $error("Master clock source mismatch");
   a_input_type: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      ##1 receiver_input_type == $past(rx_in_q[RX_TYPE_BIT]))
      else $error("Input type mismatch");
   a_irq_pair: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      (lock_loss_toggle && !mask_q[0] && !evt.status_read) |=> ##1 !irq_n)
      else $error("Unmasked lock loss did not raise interrupt");
   a_readback: assert property (@(posedge ref_clk) disable iff (bank_rst || bank_rst_q)
      (wr_en && addr == ADDR_INT_MASK) |=> mask_q == $past(wr_data))
      else $error("Mask register did not store write");
endmodule
`default_nettype wire

// File: common/csr_pkg.sv
// Package with register map, field positions and reset values of the clock and mask registers
package csr_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [6:0] ADDR_POST_DIV   = 7'h07;
   localparam logic [6:0] ADDR_CLK_SRC    = 7'h08;
   localparam logic [6:0] ADDR_RX_INPUT   = 7'h09;
   localparam logic [6:0] ADDR_INT_MASK   = 7'h0a;
   localparam logic [6:0] ADDR_INT_STATUS = 7'h0b;
   localparam logic [6:0] ADDR_DEV_RESET  = 7'h00;
   // Writable bits of each register
   localparam logic [7:0] MASK_POST_DIV   = 8'h3f;
   localparam logic [7:0] MASK_CLK_SRC    = 8'hf8;
   localparam logic [7:0] MASK_RX_INPUT   = 8'h01;
   localparam logic [7:0] MASK_INT_MASK   = 8'hff;
   // Reset values
   localparam logic [7:0] RST_POST_DIV    = 8'h16;
   localparam logic [7:0] RST_CLK_SRC     = 8'h18;
   localparam logic [7:0] RST_RX_INPUT    = 8'h01;
   localparam logic [7:0] RST_INT_MASK    = 8'h00;
   // Field positions
   localparam int POST_SCALE_LO   = 0;
   localparam int FRAC_EN_BIT     = 2;
   localparam int MCLK_DIV_BIT    = 3;
   localparam int PIN_DIV_LO      = 4;
   localparam int PIN_SRC_BIT     = 3;
   localparam int PIN_EN_BIT      = 4;
   localparam int FILL_BIT        = 5;
   localparam int IGN_INV_BIT     = 6;
   localparam int MCLK_SRC_BIT    = 7;
   localparam int RX_TYPE_BIT     = 0;
   localparam int NUM_EVENTS      = 8;
   // Event index positions
   localparam int EV_INVALID      = 1;
   typedef enum logic [1:0] {
      CSR_IDLE   = 2'b00,
      CSR_WRITE  = 2'b01,
      CSR_RESET  = 2'b11
   } csr_state_t;
endpackage

// File: common/csr_evt_if.sv
// Interface carrying receiver events and mask between the register bank and the status logic
`timescale 1ns/1ps
`default_nettype none
interface csr_evt_if;
   logic [7:0] raw_event;
   logic [7:0] int_mask;
   logic       status_read;
   logic [7:0] status;
   logic       irq;
   modport bank (output raw_event, output int_mask, output status_read,
                 input status, input irq);
   modport stat (input raw_event, input int_mask, input status_read,
                 output status, output irq);
endinterface
`default_nettype wire

// File: rtl/csr_int_status.sv
// Sticky interrupt status with per-event mask
`timescale 1ns/1ps
`default_nettype none
module csr_int_status (
   input  wire logic ref_clk,
   input  wire logic rst,
   csr_evt_if.stat   evt
);
   import csr_pkg::*;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic       irq_q;
   logic       irq_d;
   logic       rst_q;

   always_comb begin
      status_d = (evt.status_read ? 8'h00 : status_q) | (evt.raw_event & ~evt.int_mask);
      irq_d    = |status_d;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_q <= 8'h00;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q    <= irq_d;
      end
   end

   // Reset echo keeps checks quiet on the edge after a reset
   always_ff @(posedge ref_clk) begin
      rst_q <= rst;
   end

   assign evt.status = status_q;
   assign evt.irq    = irq_q;

   a_masked_no_set: assert property (@(posedge ref_clk) disable iff (rst || rst_q)
      (evt.status_read && (evt.raw_event & ~evt.int_mask) == 8'h00) |=> status_q == 8'h00)
      else $error("Status kept a bit after read with no unmasked event");
   a_event_sets_bit: assert property (@(posedge ref_clk) disable iff (rst || rst_q)
      (evt.raw_event[0] && !evt.int_mask[0]) |=> status_q[0] && irq_q)
      else $error("Unmasked event did not set status");
endmodule
`default_nettype wire

// File: bench/csr_host_model.sv
// Host model driving the register access strobes of the clock and mask registers
`timescale 1ns/1ps
`default_nettype none
module csr_host_model (
   input  wire logic       ref_clk,
   output logic            wr_en,
   output logic            rd_en,
   output logic [6:0]      addr,
   output logic [7:0]      wr_data,
   input  wire logic [7:0] rd_data
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 7'h00;
      wr_data = 8'h00;
   end
   // Write strobe held across the taking edge; data line flips once released
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge ref_clk);
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Read strobe for one edge; data taken in the following cycle
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk);
      rd_en = 1'b0;
      d = rd_data;
   endtask
endmodule
`default_nettype wire

// File: bench/csr_clock_regs_tb.sv
// Testbench for the clock select and interrupt mask registers
`timescale 1ns/1ps
`default_nettype none
module csr_clock_regs_tb;
   import csr_pkg::*;
   localparam logic [1:0] RXP = 2'b10;
   localparam logic [6:0] ADR_T [4] = '{ADDR_POST_DIV, ADDR_CLK_SRC, ADDR_RX_INPUT, ADDR_INT_MASK};
   localparam logic [7:0] RST_T [4] = '{RST_POST_DIV, RST_CLK_SRC, RST_RX_INPUT, RST_INT_MASK};
   localparam logic [7:0] MSK_T [4] = '{MASK_POST_DIV, MASK_CLK_SRC, MASK_RX_INPUT, MASK_INT_MASK};
   logic        ref_clk, sys_rst, wr_en, rd_en, rx_mode, clk_a, clk_b, osc, rx_inv;
   logic [6:0]  addr;
   logic [7:0]  wr_data, rd_data, ev, d;
   logic [23:0] smp, smp_out;
   logic [1:0]  post, pin_div;
   logic        frac, mc_sel, mc_div, pin_sel, pin_o, pin_oe, in_type, irq_n, dev_rst, seen;
   int          err_total, samples_checked;
   csr_host_model host_u (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data));
   csr_clock_regs #(.RX_POST_SCALE(RXP)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rx_mode(rx_mode),
      .pll_clock_a(clk_a), .pll_clock_b(clk_b), .oscillator_clock(osc),
      .lock_loss_toggle(ev[0]), .invalid_event(ev[1]), .channel_status_update_event(ev[2]),
      .transmission_error_event(ev[3]), .non_audio_toggle(ev[4]),
      .copy_permission_toggle(ev[5]), .deemphasis_toggle(ev[6]), .received_rate_toggle(ev[7]),
      .rx_data_invalid(rx_inv), .rx_sample_in(smp), .rd_data(rd_data),
      .post_scale_select(post), .fractional_enable(frac), .master_clock_sel(mc_sel),
      .master_clock_divider(mc_div), .clock_pin_divider(pin_div), .clock_pin_sel(pin_sel),
      .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe),
      .receiver_input_type(in_type), .rx_sample_out(smp_out), .irq_n(irq_n),
      .device_reset(dev_rst));
   always #25 ref_clk = ~ref_clk;
   task automatic chk(input string what, input logic [23:0] seen_v, input logic [23:0] exp_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp_v, seen_v);
      end
   endtask
   task automatic nw(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulse(input logic [7:0] v);
      @(negedge ref_clk);
      ev = v;
      @(negedge ref_clk);
      ev = 8'h00;
      nw(2);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      final_report();
   end
   initial begin
      ref_clk = 1'b0;
      sys_rst = 1'b1;
      rx_mode = 1'b0;
      clk_a = 1'b1;
      clk_b = 1'b0;
      osc = 1'b0;
      rx_inv = 1'b0;
      ev = 8'h00;
      smp = 24'habcdef;
      err_total = 0;
      samples_checked = 0;
      nw(12);
      sys_rst = 1'b0;
      nw(2);
      chk("post scale", 24'(post), 24'(2'b10));
      chk("fraction en", 24'(frac), 24'h1);
      chk("pin source", 24'(pin_sel), 24'h1);
      chk("pin level", 24'(pin_o), 24'(osc));
      chk("pin enable", 24'(pin_oe), 24'h1);
      chk("master source", 24'(mc_sel), 24'h0);
      chk("input type", 24'(in_type), 24'h1);
      chk("irq idle", 24'(irq_n), 24'h1);
      for (int i = 0; i < 4; i++) begin
         host_u.rd(ADR_T[i], d);
         chk("reset value", 24'(d), 24'(RST_T[i]));
         host_u.wr(ADR_T[i], 8'hff);
         host_u.rd(ADR_T[i], d);
         chk("ones readback", 24'(d), 24'(MSK_T[i]));
         host_u.wr(ADR_T[i], 8'h00);
         host_u.rd(ADR_T[i], d);
         chk("zero readback", 24'(d), 24'h0);
         host_u.wr(ADR_T[i], RST_T[i]);
      end
      host_u.wr(7'h05, 8'h5a);
      host_u.rd(7'h05, d);
      chk("unmapped read", 24'(d), 24'h0);
      $display("test registers done");
      host_u.wr(ADDR_POST_DIV, 8'h3b);
      host_u.wr(ADDR_CLK_SRC, 8'h00);
      nw(2);
      chk("post scale", 24'(post), 24'(2'b11));
      chk("fraction en", 24'(frac), 24'h0);
      chk("master div", 24'(mc_div), 24'h1);
      chk("pin div", 24'(pin_div), 24'(2'b11));
      chk("pin source", 24'(pin_sel), 24'h0);
      chk("pin enable", 24'(pin_oe), 24'h0);
      host_u.wr(ADDR_CLK_SRC, 8'h90);
      nw(2);
      chk("master source", 24'(mc_sel), 24'h1);
      chk("master div off", 24'(mc_div), 24'h0);
      chk("pin level", 24'(pin_o), 24'(clk_a));
      chk("pin enable", 24'(pin_oe), 24'h1);
      host_u.wr(ADDR_CLK_SRC, 8'h18);
      nw(2);
      chk("pin div off", 24'(pin_div), 24'h0);
      chk("pin level", 24'(pin_o), 24'(osc));
      host_u.wr(ADDR_RX_INPUT, 8'h00);
      nw(2);
      chk("input type", 24'(in_type), 24'h0);
      host_u.wr(ADDR_POST_DIV, 8'h05);
      rx_mode = 1'b1;
      nw(3);
      chk("rx post scale", 24'(post), 24'(RXP));
      rx_mode = 1'b0;
      nw(3);
      chk("post scale", 24'(post), 24'(2'b01));
      $display("test clocks done");
      nw(3);
      chk("sample pass", smp_out, 24'habcdef);
      rx_inv = 1'b1;
      smp = 24'h123456;
      nw(3);
      chk("sample hold", smp_out, 24'habcdef);
      host_u.wr(ADDR_CLK_SRC, 8'h38);
      nw(3);
      chk("sample zero", smp_out, 24'h0);
      host_u.wr(ADDR_CLK_SRC, 8'h58);
      nw(3);
      chk("sample ignore", smp_out, 24'h123456);
      rx_inv = 1'b0;
      pulse(8'h02);
      host_u.rd(ADDR_INT_STATUS, d);
      chk("invalid ignored", 24'(d), 24'h0);
      host_u.wr(ADDR_CLK_SRC, 8'h18);
      $display("test fill done");
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         chk("irq low", 24'(irq_n), 24'h0);
         host_u.rd(ADDR_INT_STATUS, d);
         chk("status bit", 24'(d), 24'(8'h01 << i));
         nw(2);
         chk("irq clear", 24'(irq_n), 24'h1);
      end
      host_u.wr(ADDR_INT_MASK, 8'hfe);
      pulse(8'hff);
      host_u.rd(ADDR_INT_STATUS, d);
      chk("part mask", 24'(d), 24'h01);
      host_u.wr(ADDR_INT_MASK, 8'hff);
      nw(2);
      pulse(8'hff);
      chk("irq masked", 24'(irq_n), 24'h1);
      host_u.rd(ADDR_INT_STATUS, d);
      chk("full mask", 24'(d), 24'h0);
      $display("test events done");
      host_u.wr(ADDR_DEV_RESET, 8'h00);
      seen = 1'b0;
      for (int i = 0; i < 4; i++) begin
         seen = seen | dev_rst;
         nw(1);
      end
      chk("device reset", 24'(seen), 24'h1);
      host_u.rd(ADDR_INT_MASK, d);
      chk("mask after reset", 24'(d), 24'(RST_INT_MASK));
      host_u.rd(ADDR_POST_DIV, d);
      chk("post after reset", 24'(d), 24'(RST_POST_DIV));
      $display("test device reset done");
      final_report();
   end
endmodule
`default_nettype wire
